// ---- ancs_top.sv ----
// auto-negotiation control, resolution and status registers
//
// Contract
// - while enabled, send advertisement word in fast link pulse bursts
// - advertised tech bits and enable bit reset from power-up straps
// - priority 100 full, 100 half, 10 full, 10 half
// - resolve highest mode common to partner word and advertisement
// - phy status: complete bit 4, duplex bit 2, speed bit 1
// - when disabled, control bit 13 sets speed, bit 8 duplex
// - while bit 12 set, forced bits do not affect mode; the code still loads them into mode in the cycle bit 12 rises from forced
// - control register enables, disables and restarts negotiation
// - status ability bits constant ones, T4 reads zero
// - status: complete bit 5, remote fault bit 4, link bit 2, preamble
// - advertisement defaults to the strapped tech bits, cleared bits leave the word
// - partner register captures base page and each next page
// - parallel detect loads 0081h or 0021h into partner register
// - expansion: fault 4, partner np 3, local np 2, page 1, partner able 0
// - both receive paths report link, one good link chooses technology
// - two good links at once set parallel detect fault
// - negotiate after reset and when link status changes after completion
// - writing one to bit 9 restarts negotiation
// - restart silences link for about 1500 ms before bursts again
module ancs_top
	import ancs_pkg::*;
#(
	parameter longint BREAK_CYCLES = ancs_pkg::BREAK_CYC
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic [3:0] STRAP_TECH_I,
	input wire logic STRAP_ANEN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	input wire logic LINK10_I,
	input wire logic LINK100_I,
	input wire logic PAGE_VALID_I,
	input wire logic [15:0] PAGE_WORD_I,
	output logic FLP_EN_O,
	output logic [15:0] FLP_WORD_O,
	output logic TX_HALT_O,
	output ancs_pkg::ancs_mode_t MODE_O,
	output logic LINK_UP_O
);
	import ancs_pkg::*;

	typedef enum {ST_IDLE, ST_BREAK, ST_NEGO, ST_DONE, ST_FORCED} ancs_state_t;

	// ==================================================
	// priority resolution over a technology nibble {100fd,100hd,10fd,10hd}
	function automatic ancs_mode_t resolve(input logic [3:0] t);
		ancs_mode_t m;
		m.speed100 = t[3] | t[2];
		m.full = t[3] | (~t[2] & t[1]);
		return m;
	endfunction : resolve

	// ==================================================
	// bus and pin capture
	ancs_bus_t bus;
	assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	logic [1:0] link_s;
	// link levels come from the analog receive paths, outside this clock
	ancs_sync #(.W(2)) u_sync (
		.MCLK_I(MCLK_I),
		.RST_N_I(RST_N_I),
		.D_I({LINK100_I, LINK10_I}),
		.Q_O(link_s)
	);
	logic link10, link100;
	assign link10 = link_s[0];
	assign link100 = link_s[1];

	// ==================================================
	// registers
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] adv_reg, adv_next;
	logic [15:0] partner_reg, partner_next;
	logic [15:0] rdata_reg;
	logic complete_reg, complete_next;
	logic pdf_reg, pdf_next;
	logic page_reg, page_next;
	logic lpan_reg, lpan_next;
	logic anen_prev_reg;
	logic link_prev_reg;
	// one cycle after reset in which the straps are caught
	logic init_reg;
	ancs_mode_t mode_reg, mode_next;
	ancs_state_t state_reg, state_next;
	// 32 bits: the default silence needs 24, the spare bits cost little
	logic [31:0] brk_cnt_reg, brk_cnt_next;

	// ==================================================
	// decode
	logic wr_ctrl, wr_adv, restart_req, anen, link_any, link_chg, anen_rise;
	assign wr_ctrl = bus.wr && (bus.addr == ADDR_CONTROL);
	assign wr_adv = bus.wr && (bus.addr == ADDR_ADVERT);
	assign anen = ctrl_reg[CTL_ANEN];
	assign restart_req = wr_ctrl && bus.wdata[CTL_RESTART] && anen;
	assign anen_rise = anen && !anen_prev_reg;
	assign link_any = link10 | link100;
	assign link_chg = (link_any != link_prev_reg) && (state_reg == ST_DONE);

	logic [3:0] common;
	assign common = adv_reg[ADV_TECH_LO +: 4] & partner_reg[ADV_TECH_LO +: 4];

	// parallel detect decision: exactly one good link technology
	logic pd_one, pd_bad;
	assign pd_one = link10 ^ link100;
	assign pd_bad = link10 & link100;

	// ==================================================
	// control and advertisement write path; restart bit self-clears
	always_comb begin
		ctrl_next = ctrl_reg;
		adv_next = adv_reg;
		if (wr_ctrl) begin
			ctrl_next = bus.wdata & 16'h3100; // keeps speed, enable, duplex
		end
		if (wr_adv) begin
			adv_next = {bus.wdata[15:5] & 11'h00f, 5'h01} | {11'h000, ADV_BASE[4:0]};
		end
	end

	// ==================================================
	// negotiation sequencer
	always_comb begin
		state_next = state_reg;
		brk_cnt_next = brk_cnt_reg;
		complete_next = complete_reg;
		partner_next = partner_reg;
		pdf_next = pdf_reg;
		page_next = page_reg;
		lpan_next = lpan_reg;
		mode_next = mode_reg;
		// a read clears the sticky flags; a set in the same cycle wins further down
		if (bus.rd && bus.addr == ADDR_EXPANSION) begin
			page_next = 1'b0; // page flag clears on read
			pdf_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (anen) begin
					state_next = ST_NEGO;
				end else begin
					state_next = ST_FORCED;
				end
			end
			ST_FORCED: begin
				mode_next.speed100 = ctrl_reg[CTL_SPEED];
				mode_next.full = ctrl_reg[CTL_DUPLEX];
				if (anen_rise) begin
					state_next = ST_BREAK;
					brk_cnt_next = '0;
				end
			end
			ST_BREAK: begin
				brk_cnt_next = brk_cnt_reg + 32'h1;
				if (longint'(brk_cnt_reg) >= BREAK_CYCLES - 1) begin
					state_next = ST_NEGO;
				end
			end
			ST_NEGO: begin
				if (PAGE_VALID_I) begin
					partner_next = PAGE_WORD_I;
					page_next = 1'b1;
					lpan_next = 1'b1;
					if (!PAGE_WORD_I[PRT_NP]) begin
						complete_next = 1'b1;
						state_next = ST_DONE;
						mode_next = resolve(adv_reg[ADV_TECH_LO +: 4] &
							PAGE_WORD_I[ADV_TECH_LO +: 4]);
					end
				end else if (pd_one) begin
					partner_next = link100 ? PD_WORD_100 : PD_WORD_10;
					lpan_next = 1'b0;
					complete_next = 1'b1;
					mode_next.speed100 = link100;
					mode_next.full = 1'b0;
					state_next = ST_DONE;
				end else if (pd_bad) begin
					pdf_next = 1'b1;
				end
			end
			ST_DONE: begin
				mode_next = lpan_reg ? resolve(common) : mode_reg;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// restart re-enters the break phase from any enabled state but forced, a link change only from done
		if (anen && (restart_req || link_chg) && state_reg != ST_FORCED) begin
			state_next = ST_BREAK;
			brk_cnt_next = '0;
			complete_next = 1'b0;
		end
		if (!anen && state_reg != ST_FORCED && state_reg != ST_IDLE) begin
			state_next = ST_FORCED;
			complete_next = 1'b0;
		end
	end

	// ==================================================
	// state registers; straps caught after reset via clocked load
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			init_reg <= 1'b1;
			ctrl_reg <= '0;
			adv_reg <= ADV_BASE;
			state_reg <= ST_IDLE;
		end else if (init_reg) begin
			init_reg <= 1'b0;
			ctrl_reg <= {3'h0, STRAP_ANEN_I, 12'h000};
			adv_reg <= {7'h00, STRAP_TECH_I, ADV_BASE[4:0]};
		end else begin
			ctrl_reg <= ctrl_next;
			adv_reg <= adv_next;
			state_reg <= state_next;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			brk_cnt_reg <= '0;
			complete_reg <= 1'b0;
			partner_reg <= '0;
			pdf_reg <= 1'b0;
			page_reg <= 1'b0;
			lpan_reg <= 1'b0;
			mode_reg <= '0;
			anen_prev_reg <= 1'b0;
			link_prev_reg <= 1'b0;
		end else begin
			brk_cnt_reg <= brk_cnt_next;
			complete_reg <= complete_next;
			partner_reg <= partner_next;
			pdf_reg <= pdf_next | (pd_bad && state_reg == ST_NEGO); // set wins over read clear
			page_reg <= page_next | (PAGE_VALID_I && state_reg == ST_NEGO);
			lpan_reg <= lpan_next;
			mode_reg <= mode_next;
			anen_prev_reg <= anen;
			link_prev_reg <= link_any;
		end
	end

	// ==================================================
	// read-back; writes to read-only offsets fall through untouched
	logic [15:0] sts_word, exp_word, phy_word, rd_mux;
	assign sts_word = STS_CONST | (16'(complete_reg) << STS_COMPLETE) |
		(16'(partner_reg[PRT_RFAULT]) << STS_RFAULT) |
		(16'(link_any) << STS_LINK);
	assign exp_word = (16'(pdf_reg) << EXP_PDF) | (16'(partner_reg[PRT_NP]) << EXP_LPNP) |
		(16'h1 << EXP_NP) | (16'(page_reg) << EXP_PAGE) |
		(16'(lpan_reg) << EXP_LPAN);
	assign phy_word = (16'(complete_reg) << PHY_COMPLETE) |
		(16'(mode_reg.full) << PHY_DUPLEX) | (16'(!mode_reg.speed100) << PHY_SPEED) |
		(16'(link_any) << PHY_LINK);
	assign rd_mux = (bus.addr == ADDR_CONTROL) ? ctrl_reg :
		(bus.addr == ADDR_STATUS) ? sts_word :
		(bus.addr == ADDR_ADVERT) ? adv_reg :
		(bus.addr == ADDR_PARTNER) ? partner_reg :
		(bus.addr == ADDR_EXPANSION) ? exp_word :
		(bus.addr == ADDR_PHY_STATUS) ? phy_word : 16'h0000;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= bus.rd ? rd_mux : 16'h0000;
		end
	end

	// ==================================================
	// outputs
	assign RDATA_O = rdata_reg;
	assign FLP_EN_O = (state_reg == ST_NEGO);
	assign FLP_WORD_O = adv_reg;
	assign TX_HALT_O = (state_reg == ST_BREAK);
	assign MODE_O = mode_reg;
	assign LINK_UP_O = link_any & (complete_reg | !anen);

	// ==================================================
	// checks
	a_break_silent: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		$rose(TX_HALT_O) |-> !FLP_EN_O [*8]) else $error("bursts during break");
	a_restart_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(restart_req && !init_reg) |=> !complete_reg) else $error("restart kept complete");
	a_pd_word: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_NEGO && !PAGE_VALID_I && pd_one && !restart_req && !link_chg && anen)
		|=> (partner_reg == PD_WORD_100 || partner_reg == PD_WORD_10))
		else $error("bad parallel detect word");
	a_pd_fault: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_NEGO && pd_bad) |=> pdf_reg) else $error("fault flag missed");
	a_forced_mode: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_FORCED && $past(state_reg) == ST_FORCED && !init_reg)
		|=> mode_reg.speed100 == $past(ctrl_reg[CTL_SPEED]))
		else $error("forced speed ignored");
	a_enabled_mode: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(anen && state_reg == ST_DONE && $changed(ctrl_reg[CTL_SPEED])) |=> $stable(mode_reg))
		else $error("forced bit moved mode");
	a_status_const: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(sts_word & STS_CONST) == STS_CONST && !sts_word[15]) else $error("ability bits");
	a_phy_complete: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		phy_word[PHY_COMPLETE] == sts_word[STS_COMPLETE]) else $error("complete mismatch");
	a_flp_enable: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		FLP_EN_O |-> anen) else $error("bursts while disabled");
	a_prio_top: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_DONE && lpan_reg && common[3]) |=> (mode_reg.speed100 && mode_reg.full))
		else $error("priority wrong");

	// ==================================================
	// capture, advertisement, parallel detect, restart and start-up
	a_page_capture: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_NEGO && PAGE_VALID_I)
		|=> partner_reg == $past(PAGE_WORD_I))
		else $error("code word not captured");
	a_page_flag: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_NEGO && PAGE_VALID_I)
		|=> page_reg)
		else $error("page flag missed");
	a_adv_write: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(wr_adv && !init_reg)
		|=> adv_reg == {7'h00, $past(WDATA_I[8:5]), ADV_BASE[4:0]})
		else $error("advertisement write wrong");
	a_pd_single: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_NEGO && !PAGE_VALID_I && pd_one && anen && !restart_req)
		|=> (state_reg == ST_DONE && !lpan_reg && complete_reg))
		else $error("single link not taken");
	a_restart_break: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(restart_req && state_reg != ST_FORCED && !init_reg)
		|=> TX_HALT_O)
		else $error("restart did not break link");
	a_nego_start: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
		(state_reg == ST_IDLE && anen && !init_reg && !restart_req)
		|=> FLP_EN_O)
		else $error("no bursts after reset");
endmodule : ancs_top

// ---- ancs_pkg.sv ----
// package of register map, field positions and timing for the negotiation block
package ancs_pkg;
	// ==================================================
	// register offsets
	localparam logic [7:0] ADDR_CONTROL = 8'h80;
	localparam logic [7:0] ADDR_STATUS = 8'h84;
	localparam logic [7:0] ADDR_ADVERT = 8'h90;
	localparam logic [7:0] ADDR_PARTNER = 8'h94;
	localparam logic [7:0] ADDR_EXPANSION = 8'h98;
	localparam logic [7:0] ADDR_PHY_STATUS = 8'hc0;
	// ==================================================
	// control field positions
	localparam int CTL_SPEED = 13;
	localparam int CTL_ANEN = 12;
	localparam int CTL_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	// advertisement technology bits
	localparam int ADV_TECH_LO = 5;
	localparam logic [15:0] ADV_BASE = 16'h0001;
	// status constant abilities: 100fd,100hd,10fd,10hd, preamble supp, an able, ext cap
	localparam logic [15:0] STS_CONST = 16'h7849;
	localparam int STS_COMPLETE = 5;
	localparam int STS_RFAULT = 4;
	localparam int STS_LINK = 2;
	localparam int PRT_RFAULT = 13;
	localparam int PRT_NP = 15;
	// parallel detect partner words
	localparam logic [15:0] PD_WORD_100 = 16'h0081;
	localparam logic [15:0] PD_WORD_10 = 16'h0021;
	// expansion bits
	localparam int EXP_PDF = 4;
	localparam int EXP_LPNP = 3;
	localparam int EXP_NP = 2;
	localparam int EXP_PAGE = 1;
	localparam int EXP_LPAN = 0;
	// phy status bits
	localparam int PHY_COMPLETE = 4;
	localparam int PHY_DUPLEX = 2;
	localparam int PHY_SPEED = 1;
	localparam int PHY_LINK = 0;
	// ==================================================
	// timing at 10 MHz
	localparam longint CLK_HZ = 10000000;
	localparam longint BREAK_MS = 1500;
	localparam longint BREAK_CYC = (BREAK_MS * CLK_HZ) / 1000;
	// ==================================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ancs_bus_t;
	typedef struct packed {
		logic speed100;
		logic full;
	} ancs_mode_t;
endpackage : ancs_pkg

// ---- ancs_sync.sv ----
// two flip-flop synchroniser for a bundle of pin levels
module ancs_sync #(
	parameter int W = 1
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic [W-1:0] D_I,
	output logic [W-1:0] Q_O
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;
	// ==================================================
	// first stage feeds only the second stage
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= D_I;
			q_reg <= meta_reg;
		end
	end
	assign Q_O = q_reg;
endmodule : ancs_sync

// ---- ancs_partner.sv ----
// link partner model: link levels and code words towards the block
module ancs_partner (
	input wire logic clk_i,
	input wire logic flp_en_i,
	input wire logic [15:0] flp_word_i,
	output logic link10_o,
	output logic link100_o,
	output logic page_valid_o,
	output logic [15:0] page_word_o,
	output logic [15:0] heard_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// quiet line at start
	initial begin
		link10_o = 1'b0;
		link100_o = 1'b0;
		page_valid_o = 1'b0;
		page_word_o = 16'h0000;
		heard_o = 16'h0000;
	end
	// a word is heard only while bursts run; silence keeps the old one
	always @(posedge clk_i) begin
		if (flp_en_i) begin
			heard_o <= flp_word_i;
		end
	end
	// one code word; the word lines flip once it is gone
	task automatic send(input logic [15:0] w);
		@(posedge clk_i);
		page_valid_o <= 1'b1;
		page_word_o <= w;
		@(posedge clk_i);
		page_valid_o <= 1'b0;
		page_word_o <= ~w;
	endtask : send
	// good link levels as the receive paths report them
	task automatic links(input logic a, input logic b);
		@(posedge clk_i);
		link10_o <= a;
		link100_o <= b;
	endtask : links
endmodule : ancs_partner

// ---- test_autoneg_control_status.sv ----
// self-checking bench for the negotiation control and status block
module test_autoneg_control_status;
	timeunit 1ns;
	timeprecision 1ns;
	import ancs_pkg::*;
	localparam longint BRK = 20; // short silence keeps the run brief
	localparam logic [7:0] RO [4] = '{ADDR_STATUS, ADDR_PARTNER, ADDR_EXPANSION, ADDR_PHY_STATUS};
	logic clk, rst_n, anen, wr, rd, flp_en, tx_halt, link_up, l10, l100, pv;
	logic [3:0] tech, mine, pt;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, pw, flp_word, heard, d, w;
	logic [1:0] m;
	ancs_mode_t mode;
	int errors, compares, n, i;
	// ====
	// design and far side
	ancs_top #(.BREAK_CYCLES(BRK)) u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .STRAP_TECH_I(tech),
		.STRAP_ANEN_I(anen), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .LINK10_I(l10), .LINK100_I(l100), .PAGE_VALID_I(pv),
		.PAGE_WORD_I(pw), .FLP_EN_O(flp_en), .FLP_WORD_O(flp_word), .TX_HALT_O(tx_halt),
		.MODE_O(mode), .LINK_UP_O(link_up));
	ancs_partner u_partner (.clk_i(clk), .flp_en_i(flp_en), .flp_word_i(flp_word),
		.link10_o(l10), .link100_o(l100), .page_valid_o(pv), .page_word_o(pw), .heard_o(heard));
	// ====
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ====
	// checking and closing
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	// a wait that ran out ends the run
	task automatic tmo();
		if (n >= 200) begin
			errors++;
			$display("[FAIL] %0t wait ran out", $time);
			results();
		end
	endtask : tmo
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	// ====
	// register bus cycles
	task automatic wreg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rreg
	// straps held steady over the release
	task automatic reset(input logic en);
		@(posedge clk);
		rst_n <= 1'b0;
		anen <= en;
		tech <= 4'($urandom_range(15, 1));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : reset
	// mode expected from the common abilities, best first
	function automatic logic [1:0] best(input logic [3:0] c);
		if (c[3]) return 2'b11;
		if (c[2]) return 2'b10;
		if (c[1]) return 2'b01;
		return 2'b00;
	endfunction : best
	// restart from completion: silence, bursts again, completion gone
	task automatic restart();
		wreg(ADDR_CONTROL, 16'h1200);
		for (n = 0; n < 200 && !tx_halt; n++) tick();
		tmo();
		check(16'(flp_en), 16'h0);
		for (n = 0; n < 200 && tx_halt; n++) tick();
		check(16'(n >= BRK - 2 && n <= BRK + 1), 16'h1);
		for (n = 0; n < 200 && !flp_en; n++) tick();
		tmo();
		rreg(ADDR_STATUS, d);
		check(d & 16'h0020, 16'h0);
	endtask : restart
	// one exchange of code words and the mode it resolves to
	task automatic nego(input logic [3:0] a, input logic [3:0] b, input logic np);
		w = {2'b0, 1'($urandom), 4'h0, b, 5'h01};
		wreg(ADDR_ADVERT, {7'h7f, a, 5'h1e});
		tick();
		check(flp_word, {7'h0, a, 5'h01});
		tick();
		check(heard, {7'h0, a, 5'h01});
		if (np) begin
			u_partner.send(w | 16'h8000);
			rreg(ADDR_PARTNER, d);
			check(d, w | 16'h8000);
			rreg(ADDR_EXPANSION, d);
			check(d, 16'h000f);
		end
		u_partner.send(w);
		m = best(a & b);
		tick();
		tick();
		check({14'h0, mode}, {14'h0, m});
		// forced bits opposite to the result must not move it
		wreg(ADDR_CONTROL, {2'b0, ~m[1], 1'b1, 3'h0, ~m[0], 8'h00});
		tick();
		tick();
		check({14'h0, mode}, {14'h0, m});
		rreg(ADDR_PHY_STATUS, d);
		check(d & 16'h0016, 16'h0010 | {13'h0, m[0], ~m[1], 1'b0});
		rreg(ADDR_PARTNER, d);
		check(d, w);
		rreg(ADDR_STATUS, d);
		check(d & 16'hfffb, STS_CONST | 16'h0020 | {11'h0, w[13], 4'h0});
		rreg(ADDR_EXPANSION, d);
		check(d & 16'h0017, 16'h0007);
		restart();
	endtask : nego
	// one good link from a partner that does not negotiate, then it drops
	task automatic pd(input logic a, input logic b, input logic [15:0] lp);
		u_partner.links(a, b);
		d = 16'h0;
		for (n = 0; n < 200 && d[5] !== 1'b1; n++) rreg(ADDR_STATUS, d);
		tmo();
		check(d & 16'h0004, 16'h0004);
		check(16'(link_up), 16'h1);
		rreg(ADDR_PARTNER, d);
		check(d, lp);
		check({14'h0, mode}, {14'h0, b, 1'b0});
		rreg(ADDR_EXPANSION, d);
		check(d & 16'h0011, 16'h0);
		u_partner.links(1'b0, 1'b0);
		for (n = 0; n < 200 && !tx_halt; n++) tick();
		tmo();
		for (n = 0; n < 200 && !flp_en; n++) tick();
		tmo();
	endtask : pd
	// ====
	// main sequence
	initial begin
		rst_n = 1'b0;
		anen = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		tech = 4'hf;
		errors = 0;
		compares = 0;
		void'($urandom(78));
		// forced mode from the straps: control bits pick the mode
		reset(1'b0);
		rreg(ADDR_CONTROL, d);
		check(d & 16'h1000, 16'h0);
		check(16'(flp_en), 16'h0);
		for (i = 0; i < 4; i++) begin
			wreg(ADDR_CONTROL, {2'b0, i[1], 4'h0, i[0], 8'h00});
			tick();
			check({14'h0, mode}, {14'h0, i[1:0]});
			rreg(ADDR_PHY_STATUS, d);
			check(d & 16'h0006, {13'h0, i[0], ~i[1], 1'b0});
		end
		// clear then set the enable; forced bits then lose their say
		wreg(ADDR_CONTROL, 16'h0000);
		wreg(ADDR_CONTROL, 16'h1000);
		for (n = 0; n < 200 && !tx_halt; n++) tick();
		tmo();
		m = mode;
		wreg(ADDR_CONTROL, 16'h3100);
		tick();
		check({14'h0, mode}, {14'h0, m});
		rreg(ADDR_CONTROL, d);
		check(d, 16'h3100);
		// negotiation enabled from the straps
		reset(1'b1);
		for (n = 0; n < 200 && !flp_en; n++) tick();
		tmo();
		rreg(ADDR_ADVERT, d);
		check(d, {7'h0, tech, 5'h01});
		rreg(ADDR_CONTROL, d);
		check(d & 16'h1000, 16'h1000);
		// read-only places keep their value, an unmapped one reads zero
		foreach (RO[k]) begin
			rreg(RO[k], w);
			wreg(RO[k], ~w);
			rreg(RO[k], d);
			check(d, w);
		end
		rreg(8'h44, d);
		check(d, 16'h0000);
		pd(1'b0, 1'b1, PD_WORD_100);
		pd(1'b1, 1'b0, PD_WORD_10);
		// corner pairs reach each mode, then random pairs
		for (i = 0; i < 10; i++) begin
			mine = (i < 4) ? 4'hf : 4'($urandom_range(15, 1));
			pt = (i < 4) ? 4'h1 << i : 4'($urandom);
			if ((mine & pt) == 4'h0) pt = mine;
			nego(mine, pt, i[0]);
		end
		// two good links at once is a fault
		u_partner.links(1'b1, 1'b1);
		d = 16'h0;
		for (n = 0; n < 200 && d[4] !== 1'b1; n++) rreg(ADDR_EXPANSION, d);
		tmo();
		check(d & 16'h0010, 16'h0010);
		results();
	end
endmodule : test_autoneg_control_status
